// File: core/gpp_pkg.sv
package gpp_pkg;

    // ==================================================================
    // widths
    localparam int          PIN_COUNT      = 8;
    localparam int          ADR_WIDTH      = 12;
    localparam int          DAT_WIDTH      = 32;
    localparam int          SEL_WIDTH      = 4;
    localparam int          MASK_LSB       = 2;
    localparam int          MASK_MSB       = 9;
    localparam int          IDENT_COUNT    = 12;

    // ==================================================================
    // register offsets (byte addresses)
    localparam logic [11:0] OFS_DATA       = 12'h000;
    localparam logic [11:0] OFS_DIR        = 12'h400;
    localparam logic [11:0] OFS_SENSE      = 12'h404;
    localparam logic [11:0] OFS_BOTH       = 12'h408;
    localparam logic [11:0] OFS_POL        = 12'h40C;
    localparam logic [11:0] OFS_IM         = 12'h410;
    localparam logic [11:0] OFS_RIS        = 12'h414;
    localparam logic [11:0] OFS_MIS        = 12'h418;
    localparam logic [11:0] OFS_ICR        = 12'h41C;
    localparam logic [11:0] OFS_AFSEL      = 12'h420;
    localparam logic [11:0] OFS_DR2        = 12'h500;
    localparam logic [11:0] OFS_DR4        = 12'h504;
    localparam logic [11:0] OFS_DR8        = 12'h508;
    localparam logic [11:0] OFS_ODR        = 12'h50C;
    localparam logic [11:0] OFS_PUR        = 12'h510;
    localparam logic [11:0] OFS_PDR        = 12'h514;
    localparam logic [11:0] OFS_SLR        = 12'h518;
    localparam logic [11:0] OFS_DEN        = 12'h51C;
    localparam logic [11:0] OFS_IDENT      = 12'hFD0;

    // ==================================================================
    // reset values
    localparam logic [7:0]  RST_ZERO       = 8'h00;
    localparam logic [7:0]  RST_DR2        = 8'hFF;
    localparam logic [7:0]  RST_PUR        = 8'hFF;
    localparam logic [7:0]  RST_DEN        = 8'hFF;
    localparam logic [7:0]  AFSEL_PORT_B   = 8'h80;
    localparam logic [7:0]  AFSEL_PORT_C   = 8'h0F;

    // ==================================================================
    // carriers
    typedef struct packed {
        logic [PIN_COUNT-1:0] pull_up_select;
        logic [PIN_COUNT-1:0] pull_down_select;
        logic [PIN_COUNT-1:0] drive_low_select;
        logic [PIN_COUNT-1:0] drive_mid_select;
        logic [PIN_COUNT-1:0] drive_high_select;
        logic [PIN_COUNT-1:0] open_drain_select;
        logic [PIN_COUNT-1:0] slew_control_select;
        logic [PIN_COUNT-1:0] digital_input_enable;
    } gpp_pad_type;

    typedef struct packed {
        logic [PIN_COUNT-1:0] irq_sense_select;
        logic [PIN_COUNT-1:0] irq_both_edges;
        logic [PIN_COUNT-1:0] irq_polarity;
    } gpp_irq_cfg_type;

endpackage : gpp_pkg

// File: core/gpp_irq_detect.sv
module gpp_irq_detect (
    input  wire logic                      clk,
    input  wire logic                      resetn,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] pin_level,
    input  wire gpp_pkg::gpp_irq_cfg_type  cfg,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] clear_pulse,
    output logic      [gpp_pkg::PIN_COUNT-1:0] raw_irq_status
);
    import gpp_pkg::*;

    // ==================================================================
    // edge history
    logic [PIN_COUNT-1:0] prev_reg;
    logic                 primed_reg;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
    logic [PIN_COUNT-1:0] edge_hit;
    logic [PIN_COUNT-1:0] level_hit;
    logic [PIN_COUNT-1:0] raw_reg;
    logic [PIN_COUNT-1:0] raw_next;

    // first cycle after reset has no history, so no edge is reported
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_reg   <= RST_ZERO;
            primed_reg <= 1'b0;
        end else begin
            prev_reg   <= pin_level;
            primed_reg <= 1'b1;
        end
    end

    always_comb begin
        rise      = pin_level & ~prev_reg & {PIN_COUNT{primed_reg}};
        fall      = ~pin_level & prev_reg & {PIN_COUNT{primed_reg}};
        level_hit = (pin_level & cfg.irq_polarity) | (~pin_level & ~cfg.irq_polarity);
        edge_hit  = (cfg.irq_both_edges & (rise | fall))
                  | (~cfg.irq_both_edges & cfg.irq_polarity & rise)
                  | (~cfg.irq_both_edges & ~cfg.irq_polarity & fall);
        // level pins follow the match; edge pins latch and a new edge beats the clear
        raw_next  = (cfg.irq_sense_select & level_hit)
                  | (~cfg.irq_sense_select & (edge_hit | (raw_reg & ~clear_pulse)));
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            raw_reg <= RST_ZERO;
        end else begin
            raw_reg <= raw_next;
        end
    end

    assign raw_irq_status = raw_reg;

endmodule : gpp_irq_detect

// File: core/gpp_port.sv
module gpp_port #(
    // one instance per port, debug pins differ per port
    parameter logic [7:0]  AFSEL_RESET  = gpp_pkg::RST_ZERO,
    // arbitrary neutral identification bytes, lowest offset last
    parameter logic [95:0] IDENT_VALUES = 96'h00_00_00_00_5A_3C_11_22_0A_0B_0C_0D
) (
    input  wire logic                          clk,
    input  wire logic                          resetn,
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [gpp_pkg::ADR_WIDTH-1:0] wb_adr_i,
    input  wire logic [gpp_pkg::SEL_WIDTH-1:0] wb_sel_i,
    input  wire logic [gpp_pkg::DAT_WIDTH-1:0] wb_dat_i,
    output logic      [gpp_pkg::DAT_WIDTH-1:0] wb_dat_o,
    output logic                               wb_ack_o,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] pin_in,
    output logic      [gpp_pkg::PIN_COUNT-1:0] pin_out,
    output logic      [gpp_pkg::PIN_COUNT-1:0] pin_oe,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] alt_out,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] alt_oe,
    output logic      [gpp_pkg::PIN_COUNT-1:0] alt_in,
    output gpp_pkg::gpp_pad_type               pad_cfg,
    output logic                               irq
);
    import gpp_pkg::*;

    // ==================================================================
    // helpers
    function automatic logic [PIN_COUNT-1:0] adr_mask(input logic [ADR_WIDTH-1:0] adr);
        adr_mask = adr[MASK_MSB:MASK_LSB];
    endfunction : adr_mask

    function automatic logic [PIN_COUNT-1:0] masked_update(
        input logic [PIN_COUNT-1:0] old_val,
        input logic [PIN_COUNT-1:0] new_val,
        input logic [PIN_COUNT-1:0] mask
    );
        masked_update = (old_val & ~mask) | (new_val & mask);
    endfunction : masked_update

    // ==================================================================
    // registers
    logic [PIN_COUNT-1:0] port_data_reg;
    logic [PIN_COUNT-1:0] pin_direction_reg;
    logic [PIN_COUNT-1:0] irq_enable_mask_reg;
    logic [PIN_COUNT-1:0] alt_function_select_reg;
    gpp_irq_cfg_type      irq_cfg_reg;
    gpp_pad_type          pad_reg;
    gpp_pad_type          pad_out_reg;
    gpp_pad_type          pad_out_next;
    logic                 ack_reg;
    logic [DAT_WIDTH-1:0] rdata_reg;
    logic [DAT_WIDTH-1:0] rdata_next;
    logic [PIN_COUNT-1:0] pin_out_reg;
    logic [PIN_COUNT-1:0] pin_oe_reg;
    logic [PIN_COUNT-1:0] pin_out_next;
    logic [PIN_COUNT-1:0] pin_oe_next;
    logic [PIN_COUNT-1:0] alt_in_reg;
    logic                 irq_reg;

    // ==================================================================
    // bus decode
    logic                 bus_req;
    logic                 wr_en;
    logic                 data_hit;
    logic [PIN_COUNT-1:0] wr_val;
    logic [PIN_COUNT-1:0] wr_mask;
    logic [PIN_COUNT-1:0] irq_clear;
    logic [PIN_COUNT-1:0] pin_sampled;
    logic [PIN_COUNT-1:0] sw_out;
    logic [PIN_COUNT-1:0] raw_irq_status;
    logic [PIN_COUNT-1:0] masked_irq_status;
    logic [PIN_COUNT-1:0] ident_byte;
    logic [ADR_WIDTH-1:0] ident_ofs;
    logic [3:0]           ident_idx;

    assign bus_req  = wb_cyc_i & wb_stb_i;
    // writes land on the edge that samples ack, as the master expects
    assign wr_en    = bus_req & wb_we_i & ack_reg & wb_sel_i[0];
    assign data_hit = (wb_adr_i < OFS_DIR);
    assign wr_val   = wb_dat_i[PIN_COUNT-1:0];
    assign wr_mask  = adr_mask(wb_adr_i);
    assign irq_clear = (wr_en && wb_adr_i == OFS_ICR) ? wr_val : RST_ZERO;

    // input enable gates what the port and peripherals see
    assign pin_sampled = pin_in & pad_reg.digital_input_enable;
    assign sw_out      = pin_direction_reg & ~alt_function_select_reg;
    assign masked_irq_status = raw_irq_status & irq_enable_mask_reg;

    // ==================================================================
    // interrupt detection
    gpp_irq_detect u_detect (
        .clk            (clk),
        .resetn         (resetn),
        .pin_level      (pin_sampled),
        .cfg            (irq_cfg_reg),
        .clear_pulse    (irq_clear),
        .raw_irq_status (raw_irq_status)
    );

    // ==================================================================
    // bus handshake: ack one cycle after the request, dropped the next
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= '0;
        end else if (bus_req && !ack_reg && !wb_we_i) begin
            rdata_reg <= rdata_next;
        end
    end

    // ==================================================================
    // data register
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port_data_reg <= RST_ZERO;
        end else if (wr_en && data_hit) begin
            port_data_reg <= masked_update(port_data_reg, wr_val, wr_mask);
        end
    end

    // ==================================================================
    // direction and mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_direction_reg <= RST_ZERO;
        end else if (wr_en && wb_adr_i == OFS_DIR) begin
            pin_direction_reg <= wr_val;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alt_function_select_reg <= AFSEL_RESET;
        end else if (wr_en && wb_adr_i == OFS_AFSEL) begin
            alt_function_select_reg <= wr_val;
        end
    end

    // ==================================================================
    // interrupt configuration
    // changing these while a pin is unmasked may raise a spurious event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_cfg_reg <= '0;
        end else if (wr_en) begin
            if (wb_adr_i == OFS_SENSE) begin
                irq_cfg_reg.irq_sense_select <= wr_val;
            end
            if (wb_adr_i == OFS_BOTH) begin
                irq_cfg_reg.irq_both_edges <= wr_val;
            end
            if (wb_adr_i == OFS_POL) begin
                irq_cfg_reg.irq_polarity <= wr_val;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_enable_mask_reg <= RST_ZERO;
        end else if (wr_en && wb_adr_i == OFS_IM) begin
            irq_enable_mask_reg <= wr_val;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |masked_irq_status;
        end
    end

    // ==================================================================
    // pad configuration
    // a drive strength bit set in one select is cleared in the other two
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad_reg.drive_low_select  <= RST_DR2;
            pad_reg.drive_mid_select  <= RST_ZERO;
            pad_reg.drive_high_select <= RST_ZERO;
        end else if (wr_en) begin
            if (wb_adr_i == OFS_DR2) begin
                pad_reg.drive_low_select  <= wr_val;
                pad_reg.drive_mid_select  <= pad_reg.drive_mid_select & ~wr_val;
                pad_reg.drive_high_select <= pad_reg.drive_high_select & ~wr_val;
            end
            if (wb_adr_i == OFS_DR4) begin
                pad_reg.drive_mid_select  <= wr_val;
                pad_reg.drive_low_select  <= pad_reg.drive_low_select & ~wr_val;
                pad_reg.drive_high_select <= pad_reg.drive_high_select & ~wr_val;
            end
            if (wb_adr_i == OFS_DR8) begin
                pad_reg.drive_high_select <= wr_val;
                pad_reg.drive_low_select  <= pad_reg.drive_low_select & ~wr_val;
                pad_reg.drive_mid_select  <= pad_reg.drive_mid_select & ~wr_val;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad_reg.open_drain_select    <= RST_ZERO;
            pad_reg.pull_up_select       <= RST_PUR;
            pad_reg.pull_down_select     <= RST_ZERO;
            pad_reg.slew_control_select  <= RST_ZERO;
            pad_reg.digital_input_enable <= RST_DEN;
        end else if (wr_en) begin
            if (wb_adr_i == OFS_ODR) begin
                pad_reg.open_drain_select <= wr_val;
            end
            if (wb_adr_i == OFS_PUR) begin
                pad_reg.pull_up_select <= wr_val;
            end
            if (wb_adr_i == OFS_PDR) begin
                pad_reg.pull_down_select <= wr_val;
            end
            if (wb_adr_i == OFS_SLR) begin
                pad_reg.slew_control_select <= wr_val;
            end
            if (wb_adr_i == OFS_DEN) begin
                pad_reg.digital_input_enable <= wr_val;
            end
        end
    end

    // ==================================================================
    // pin drive
    // open drain only ever pulls low; a high is left to the pull-up
    always_comb begin
        pin_out_next = (alt_function_select_reg & alt_out)
                     | (~alt_function_select_reg & port_data_reg);
        pin_oe_next  = (alt_function_select_reg & alt_oe)
                     | sw_out;
        pin_oe_next  = (~pad_reg.open_drain_select & pin_oe_next)
                     | (pad_reg.open_drain_select & pin_oe_next & ~pin_out_next);
        pin_out_next = pin_out_next & ~pad_reg.open_drain_select;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_out_reg <= RST_ZERO;
            pin_oe_reg  <= RST_ZERO;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg  <= pin_oe_next;
        end
    end

    // peripherals only see pins handed to them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alt_in_reg <= RST_ZERO;
        end else begin
            alt_in_reg <= pin_sampled & alt_function_select_reg;
        end
    end

    // ==================================================================
    // read mux
    assign ident_ofs = wb_adr_i - OFS_IDENT;
    assign ident_idx = ident_ofs[5:2];

    always_comb begin
        ident_byte = IDENT_VALUES[ident_idx*8 +: 8];
        rdata_next = '0;
        if (data_hit) begin
            // output pins not handed to a peripheral return what was written, others the pin level
            rdata_next[PIN_COUNT-1:0] = ((sw_out & port_data_reg)
                                      | (~sw_out & pin_sampled)) & wr_mask;
        end else if (wb_adr_i >= OFS_IDENT) begin
            rdata_next[PIN_COUNT-1:0] = ident_byte;
        end else begin
            unique case (wb_adr_i)
                OFS_DIR:   rdata_next[PIN_COUNT-1:0] = pin_direction_reg;
                OFS_SENSE: rdata_next[PIN_COUNT-1:0] = irq_cfg_reg.irq_sense_select;
                OFS_BOTH:  rdata_next[PIN_COUNT-1:0] = irq_cfg_reg.irq_both_edges;
                OFS_POL:   rdata_next[PIN_COUNT-1:0] = irq_cfg_reg.irq_polarity;
                OFS_IM:    rdata_next[PIN_COUNT-1:0] = irq_enable_mask_reg;
                OFS_RIS:   rdata_next[PIN_COUNT-1:0] = raw_irq_status;
                OFS_MIS:   rdata_next[PIN_COUNT-1:0] = masked_irq_status;
                OFS_AFSEL: rdata_next[PIN_COUNT-1:0] = alt_function_select_reg;
                OFS_DR2:   rdata_next[PIN_COUNT-1:0] = pad_reg.drive_low_select;
                OFS_DR4:   rdata_next[PIN_COUNT-1:0] = pad_reg.drive_mid_select;
                OFS_DR8:   rdata_next[PIN_COUNT-1:0] = pad_reg.drive_high_select;
                OFS_ODR:   rdata_next[PIN_COUNT-1:0] = pad_reg.open_drain_select;
                OFS_PUR:   rdata_next[PIN_COUNT-1:0] = pad_reg.pull_up_select;
                OFS_PDR:   rdata_next[PIN_COUNT-1:0] = pad_reg.pull_down_select;
                OFS_SLR:   rdata_next[PIN_COUNT-1:0] = pad_reg.slew_control_select;
                OFS_DEN:   rdata_next[PIN_COUNT-1:0] = pad_reg.digital_input_enable;
                // unmapped and write-only locations read as zero
                default:   rdata_next = '0;
            endcase
        end
    end

    // ==================================================================
    // outputs
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign pin_out  = pin_out_reg;
    assign pin_oe   = pin_oe_reg;
    assign alt_in   = alt_in_reg;
    assign irq      = irq_reg;
    assign pad_cfg  = pad_out_reg;

    // slew control only takes effect on pins set to the strongest drive
    always_comb begin
        pad_out_next                     = pad_reg;
        pad_out_next.slew_control_select = pad_reg.slew_control_select
                                         & pad_reg.drive_high_select;
    end

    // registered so the pads never see a gating glitch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pad_out_reg <= '{pull_up_select: RST_PUR, drive_low_select: RST_DR2,
                             digital_input_enable: RST_DEN, default: RST_ZERO};
        end else begin
            pad_out_reg <= pad_out_next;
        end
    end

endmodule : gpp_port

// File: dv/gpp_port_checker.sv
// ==========================================
// port checks, bound to every gpp_port instance
module gpp_port_checker #(
    parameter logic [95:0] IDENT_VALUES = 96'h0
) (
    input wire logic                          clk,
    input wire logic                          resetn,
    input wire logic                          wb_cyc_i,
    input wire logic                          wb_stb_i,
    input wire logic                          wb_we_i,
    input wire logic [gpp_pkg::ADR_WIDTH-1:0] wb_adr_i,
    input wire logic [gpp_pkg::DAT_WIDTH-1:0] wb_dat_o,
    input wire logic                          wb_ack_o,
    input wire logic [gpp_pkg::PIN_COUNT-1:0] pin_out,
    input wire gpp_pkg::gpp_pad_type          pad_cfg,
    input wire logic                          irq
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpp_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence req_taken_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence read_ack_s(logic [11:0] a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    ack_pulse_a: assert property (req_taken_s |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not a single pulse one cycle after the request");
    data_mask_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:10] == 2'h0 |-> (wb_dat_o[7:0] & ~wb_adr_i[9:2]) == 8'h00)
        else $error("masked data bit read back as one");
    ident_read_a: assert property (read_ack_s(OFS_IDENT) |-> wb_dat_o == {24'h0, IDENT_VALUES[7:0]})
        else $error("first identification byte wrong");
    clear_read_a: assert property (read_ack_s(OFS_ICR) |-> wb_dat_o == 32'h0)
        else $error("interrupt clear location reads nonzero");
    irq_masked_a: assert property (read_ack_s(OFS_MIS) |-> irq == (wb_dat_o[7:0] != 8'h00))
        else $error("port interrupt disagrees with masked status");
    slew_gate_a: assert property ((pad_cfg.slew_control_select & ~pad_cfg.drive_high_select) == 8'h00)
        else $error("slew control active without high drive");
    drive_one_a: assert property (((pad_cfg.drive_low_select & pad_cfg.drive_mid_select) | (pad_cfg.drive_high_select &
        (pad_cfg.drive_low_select | pad_cfg.drive_mid_select))) == 8'h00)
        else $error("two drive strengths selected on one pin");
    od_low_a: assert property ($stable(pad_cfg.open_drain_select) |-> (pin_out & pad_cfg.open_drain_select) == 8'h00)
        else $error("open drain pin driven high");
endmodule : gpp_port_checker

// File: dv/gpp_pins_model.sv
// ==========================================
// external pins and alternate peripheral
module gpp_pins_model (
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] pin_out,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] pin_oe,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] ext_level,
    input  wire logic [gpp_pkg::PIN_COUNT-1:0] periph_val,
    output logic      [gpp_pkg::PIN_COUNT-1:0] pin_in,
    output logic      [gpp_pkg::PIN_COUNT-1:0] alt_out,
    output logic      [gpp_pkg::PIN_COUNT-1:0] alt_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    // outside sources hold their level until the bench moves them
    assign pin_in  = (pin_oe & pin_out) | (~pin_oe & ext_level);
    assign alt_out = periph_val;
    assign alt_oe  = 8'hFF;
endmodule : gpp_pins_model

// File: dv/gpp_port_tb_top.sv
module gpp_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import gpp_pkg::*;
    // arbitrary identification bytes
    localparam logic [95:0] IDV = 96'h00_00_00_00_5A_3C_11_22_0A_0B_0C_0D;
    localparam logic [11:0] RV_OFS [7] = '{OFS_AFSEL, OFS_DIR, OFS_DR2, OFS_DR4, OFS_PUR, OFS_DEN, OFS_ICR};
    localparam logic [7:0]  RV_EXP [7] = '{AFSEL_PORT_B, RST_ZERO, RST_DR2, RST_ZERO, RST_PUR, RST_DEN, RST_ZERO};
    // {sense, both, polarity, level before, level after}
    localparam logic [4:0]  MODES  [5] = '{5'h05, 5'h02, 5'h09, 5'h15, 5'h12};
    logic        clk, resetn, wb_cyc_i, wb_stb_i, wb_we_i, irq;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i, sel_v;
    logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
    logic [7:0]  pin_in, pin_out, pin_oe, alt_out, alt_oe, alt_in, ext, pv, m, pm, v, exp8;
    logic [4:0]  md;
    logic        wb_ack_o;
    gpp_pad_type pad_cfg;
    int          error_cnt, checks_done;
    gpp_port #(.AFSEL_RESET(AFSEL_PORT_B), .IDENT_VALUES(IDV)) dut_u (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_in, .pin_out, .pin_oe,
        .alt_out, .alt_oe, .alt_in, .pad_cfg, .irq);
    gpp_pins_model pins_u (.pin_out, .pin_oe, .ext_level(ext), .periph_val(pv), .pin_in, .alt_out, .alt_oe);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // ==========================================
    // classic wishbone cycle; ack and read data taken at the same rising edge
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= sel_v;
        do @(posedge clk); while (wb_ack_o !== 1'b1 && n++ < 100);
        if (wb_ack_o !== 1'b1) begin
            error_cnt++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        // one idle edge so a landed write is visible to the caller
        @(posedge clk);
    endtask : bus
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic reset_check();
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        foreach (RV_OFS[i]) begin
            bus(1'b0, RV_OFS[i], 32'h0);
            chk(rd, {24'h0, RV_EXP[i]});
        end
    endtask : reset_check
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #200us;
        error_cnt++;
        print_verdict();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {ext, pv, exp8, error_cnt, checks_done, seed} = {8'h00, 8'h00, 8'h00, 32'h0, 32'h0, 32'h286C};
        sel_v = 4'hF;
        reset_check();
        for (int k = 0; k < IDENT_COUNT; k++) begin
            bus(1'b0, OFS_IDENT + 12'(4 * k), 32'h0);
            chk(rd, {24'h0, IDV[8*k+:8]});
        end
        bus(1'b0, 12'h600, 32'h0);
        chk(rd, 32'h0);
        chk({24'h0, pin_oe}, 32'h80);
        // a write without the low byte lane enabled must be ignored
        sel_v = 4'hE;
        bus(1'b1, OFS_DIR, 32'hFF);
        sel_v = 4'hF;
        bus(1'b0, OFS_DIR, 32'h0);
        chk(rd, 32'h0);
        bus(1'b1, OFS_AFSEL, 32'h0);
        bus(1'b1, OFS_DIR, 32'hFF);
        for (int i = 0; i < 24; i++) begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd();
            v = rnd();
            bus(1'b1, {2'b00, m, 2'b00}, {24'h0, v});
            exp8 = (exp8 & ~m) | (v & m);
            pm = rnd();
            bus(1'b0, {2'b00, pm, 2'b00}, 32'h0);
            chk(rd, {24'h0, exp8 & pm});
            chk({24'h0, pin_out}, {24'h0, exp8});
        end
        bus(1'b1, OFS_DIR, 32'h0F);
        ext <= rnd();
        bus(1'b0, 12'h3FC, 32'h0);
        chk(rd, {24'h0, (exp8 & 8'h0F) | (ext & 8'hF0)});
        bus(1'b1, OFS_AFSEL, 32'h80);
        pv <= rnd();
        repeat (3) @(posedge clk);
        chk({23'h0, pin_out[7], alt_in}, {23'h0, pv[7], pv[7], 7'h0});
        bus(1'b1, OFS_DR8, 32'h0F);
        bus(1'b1, OFS_SLR, 32'hFF);
        @(posedge clk);
        chk({24'h0, pad_cfg.slew_control_select}, 32'h0F);
        bus(1'b1, OFS_ODR, 32'h80);
        @(posedge clk);
        chk({16'h0, pin_out, pin_oe}, {16'h0, 1'b0, exp8[6:0], ~pv[7], 7'h0F});
        bus(1'b1, OFS_DIR, 32'h0);
        foreach (MODES[i]) begin
            md = MODES[i];
            bus(1'b1, OFS_IM, 32'h0);
            ext <= {ext[7:1], md[1]};
            bus(1'b1, OFS_SENSE, {31'h0, md[4]});
            bus(1'b1, OFS_BOTH, {31'h0, md[3]});
            bus(1'b1, OFS_POL, {31'h0, md[2]});
            bus(1'b1, OFS_ICR, 32'hFF);
            bus(1'b1, OFS_IM, 32'h01);
            ext <= {ext[7:1], md[0]};
            repeat (3) @(posedge clk);
            bus(1'b0, OFS_RIS, 32'h0);
            chk(rd, 32'h1);
            bus(1'b0, OFS_MIS, 32'h0);
            chk(rd, 32'h1);
            chk({31'h0, irq}, 32'h1);
            bus(1'b1, OFS_ICR, 32'hFE);
            bus(1'b0, OFS_RIS, 32'h0);
            chk(rd, 32'h1);
            bus(1'b1, OFS_ICR, 32'h01);
            bus(1'b0, OFS_RIS, 32'h0);
            chk(rd, {31'h0, md[4]});
            bus(1'b1, OFS_IM, 32'h0);
            bus(1'b0, OFS_MIS, 32'h0);
            chk(rd, 32'h0);
            chk({31'h0, irq}, 32'h0);
        end
        reset_check();
        print_verdict();
    end
endmodule : gpp_port_tb_top
bind gpp_port gpp_port_checker #(.IDENT_VALUES(IDENT_VALUES)) chk_u (.clk, .resetn, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .pin_out, .pad_cfg, .irq);
